// >>> bench/spsq_far_model.sv
// Far-side model: configuration image loader and PLL output clock watch.
`timescale 1ns/100ps
module spsq_far_model #(
	parameter int NPLL = 2,
	parameter int LOADDLY = 40
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cfgLoadStart,
	input wire logic [NPLL-1:0] pllOutEn,
	output logic cfgLoadDone,
	output logic [NPLL-1:0] pllClkLow
);
	int loadCnt = 0; // Cycles left of the image load.
	int lowCnt [NPLL]; // Cycles since each PLL output was gated.
	initial begin
		cfgLoadDone = 1'b0;
		pllClkLow = '0;
	end
	// Done is a one-cycle pulse, so no stale level survives a later reload.
	always @(posedge sys_clk) begin
		cfgLoadDone <= 1'b0;
		if (sys_rst || cfgLoadStart) begin
			loadCnt <= sys_rst ? 0 : LOADDLY;
		end else if (loadCnt > 0) begin
			loadCnt <= loadCnt - 1;
			cfgLoadDone <= (loadCnt == 1);
		end
		// The second PLL is slow to bring its clocks low.
		for (int i = 0; i < NPLL; i++) begin
			lowCnt[i] <= pllOutEn[i] ? 0 : lowCnt[i] + 1;
			pllClkLow[i] <= !pllOutEn[i] && lowCnt[i] >= 1 + 5 * i;
		end
	end
endmodule : spsq_far_model

// >>> bench/spsq_properties.sv
// Concurrent checks on the ports of the standby and power-on sequencer.
`timescale 1ns/100ps
module spsq_properties #(
	parameter int NPLL = 2,
	parameter int NBANK = 4,
	parameter int NCLK = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic coreSupplyOk,
	input wire logic cfgBankSupplyOk,
	input wire logic cfgLoadDone,
	input wire logic [NPLL-1:0] pllClkLow,
	input wire logic refEn,
	input wire logic porMonEn,
	input wire logic lpDetEn,
	input wire logic oscEn,
	input wire logic [NPLL-1:0] pllPwrEn,
	input wire logic [NPLL-1:0] pllOutEn,
	input wire logic [NBANK-1:0] diffBufEn,
	input wire logic [NCLK-1:0] clkNetEn,
	input wire logic ioRelease,
	input wire logic cfgLoadStart,
	input wire logic stbyActive
);
	// All checks run on the one system clock and rest during reset.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	AST_APB_READY: assert property (psel && !penable && ce |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	AST_LPDET_ON: assert property (lpDetEn)
		else $error("fallback detector switched off");
	AST_CFG_START: assert property ($rose(cfgLoadStart) |-> $past(coreSupplyOk && cfgBankSupplyOk))
		else $error("load started without good supplies");
	AST_IO_HOLD: assert property ($rose(ioRelease) |-> $past(cfgLoadDone))
		else $error("I/O released before load done");
	AST_IO_TRI: assert property (!ioRelease && !$past(ioRelease) |-> clkNetEn == '0 && diffBufEn == '0)
		else $error("enables on while I/O held");
	AST_REF_DEPS: assert property ($fell(refEn) |-> ##[0:2] (!porMonEn && !oscEn && pllPwrEn == '0 && diffBufEn == '0))
		else $error("dependents still on with reference off");
	AST_WAKE_REF_FIRST: assert property ($rose(porMonEn) || $rose(oscEn) |-> $past(refEn, 49))
		else $error("dependent restored before reference settled");
	// Each PLL is checked on its own powering down and restart.
	for (genvar i = 0; i < NPLL; i++) begin : gPll
		AST_PLL_DOWN: assert property ($fell(pllPwrEn[i]) && $past(stbyActive) |-> $past(!pllOutEn[i] && pllClkLow[i]))
			else $error("PLL powered down with live clocks");
		AST_PLL_OUT_LAST: assert property ($rose(pllOutEn[i]) |-> pllPwrEn[i] && !stbyActive)
			else $error("PLL output enabled too early");
	end
	COV_STBY: cover property ($rose(stbyActive));
	COV_REF_OFF: cover property ($fell(refEn));
	COV_RELEASE: cover property ($rose(ioRelease));
endmodule : spsq_properties
bind spsq_seq spsq_properties #(.NPLL(NPLL), .NBANK(NBANK), .NCLK(NCLK)) spsq_properties_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
	.coreSupplyOk(coreSupplyOk), .cfgBankSupplyOk(cfgBankSupplyOk), .cfgLoadDone(cfgLoadDone),
	.pllClkLow(pllClkLow), .refEn(refEn), .porMonEn(porMonEn), .lpDetEn(lpDetEn), .oscEn(oscEn),
	.pllPwrEn(pllPwrEn), .pllOutEn(pllOutEn), .diffBufEn(diffBufEn), .clkNetEn(clkNetEn),
	.ioRelease(ioRelease), .cfgLoadStart(cfgLoadStart), .stbyActive(stbyActive));

// >>> bench/tb.sv
// Self-checking bench for the standby and power-on sequencer.
`timescale 1ns/100ps
module tb;
	logic sys_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rs = 32'h02B3, q, mBank, mClk, mIb, mPll, c;
	logic pready, pslverr, e, stdbyToggle = 1'b0, extStdbyCmd = 1'b0, extWakeCmd = 1'b0;
	logic serStdbyReq = 1'b0, serWakeReq = 1'b0, tmrWakeReq = 1'b0;
	logic coreSupplyOk = 1'b1, cfgBankSupplyOk = 1'b1, lpDetOk = 1'b1, cfgLoadDone;
	logic refEn, porMonEn, lpDetEn, oscEn, ioRelease, cfgLoadStart, stbyActive;
	logic [1:0] pllClkLow, pllPwrEn, pllOutEn;
	logic [3:0] diffBufEn;
	logic [7:0] clkNetEn, ibufEn;
	int mismatches = 0, num_checks = 0, cycles = 0, n, r;
	// Per round: configuration, standby source and wake source.
	localparam logic [7:0] CFGS [4] = '{8'h41, 8'h76, 8'h48, 8'hE0};
	localparam int SRC [4] = '{0, 1, 5, 3};
	localparam int WAKE [4] = '{2, 0, 6, 4};
	localparam logic [31:0] RV [5] = '{32'h40, 32'h0, 32'hF, 32'hFF, 32'h0};
	always #2 sys_clk = ~sys_clk;
	spsq_seq spsq_seq_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stdbyToggle(stdbyToggle), .extStdbyCmd(extStdbyCmd), .extWakeCmd(extWakeCmd), .serStdbyReq(serStdbyReq),
		.serWakeReq(serWakeReq), .tmrWakeReq(tmrWakeReq), .coreSupplyOk(coreSupplyOk),
		.cfgBankSupplyOk(cfgBankSupplyOk), .lpDetOk(lpDetOk), .cfgLoadDone(cfgLoadDone), .pllClkLow(pllClkLow),
		.refEn(refEn), .porMonEn(porMonEn), .lpDetEn(lpDetEn), .oscEn(oscEn), .pllPwrEn(pllPwrEn),
		.pllOutEn(pllOutEn), .diffBufEn(diffBufEn), .clkNetEn(clkNetEn), .ibufEn(ibufEn), .ioRelease(ioRelease),
		.cfgLoadStart(cfgLoadStart), .stbyActive(stbyActive));
	spsq_far_model spsq_far_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfgLoadStart(cfgLoadStart),
		.pllOutEn(pllOutEn), .cfgLoadDone(cfgLoadDone), .pllClkLow(pllClkLow));
	// Pseudo-random register contents.
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; read data and error land in q and e.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for ready.
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	// Issues one standby or wake request from the chosen source.
	task automatic req(input int k);
		case (k)
			0: stdbyToggle <= ~stdbyToggle;
			1: extStdbyCmd <= 1'b1;
			2: extWakeCmd <= 1'b1;
			3: serStdbyReq <= 1'b1;
			4: tmrWakeReq <= 1'b1;
			5: apb(1'b1, spsq_pkg::ADDR_CTRL, 32'h1);
			default: apb(1'b1, spsq_pkg::ADDR_CTRL, 32'h2);
		endcase
		@(posedge sys_clk);
		{extStdbyCmd, extWakeCmd, serStdbyReq, tmrWakeReq} <= 4'h0;
		@(posedge sys_clk);
	endtask : req
	// Polls the status register until the sequencer shows state s.
	task automatic wait_state(input logic [2:0] s);
		for (int k = 0; k < 300; k++) begin
			apb(1'b0, spsq_pkg::ADDR_STATUS, 32'h0);
			if (q[2:0] === s) break;
		end
	endtask : wait_state
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	// A hang is cut short and counted as a mismatch.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Main sequence.
	initial begin
		mPll = 32'h0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (r = 1; r < 6; r++) begin
			apb(1'b0, 8'(4 * r), 32'h0);
			chk("reset", q, RV[r-1]);
		end
		chk("tristate", {ioRelease, clkNetEn}, 9'h0);
		wait_state(3'd2);
		chk("status", q, 32'h32);
		rs = xorshift(rs);
		mBank = rs & 32'hF;
		apb(1'b1, spsq_pkg::ADDR_BANKEN, rs);
		rs = xorshift(rs);
		mClk = rs & 32'hFF;
		apb(1'b1, spsq_pkg::ADDR_CLKEN, rs);
		rs = xorshift(rs);
		mIb = rs & 32'hFF;
		apb(1'b1, spsq_pkg::ADDR_IBGATE, rs);
		apb(1'b1, spsq_pkg::ADDR_STATUS, 32'h0);
		apb(1'b0, spsq_pkg::ADDR_STATUS, 32'h0);
		chk("ro", q, 32'h32);
		apb(1'b0, spsq_pkg::ADDR_CLKEN, 32'h0);
		chk("clkreg", q, mClk);
		apb(1'b1, 8'h1C, 32'h0);
		chk("unmapped", e, 1'b1);
		chk("outs", {diffBufEn, clkNetEn, ibufEn}, {mBank[3:0], mClk[7:0], mIb[7:0] ^ 8'hFF});
		// A low clock enable must swallow a standby request completely.
		ce <= 1'b0;
		extStdbyCmd <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("freeze", stbyActive, 1'b0);
		{ce, extStdbyCmd} <= 2'b10;
		@(posedge sys_clk);
		for (r = 0; r < 4; r++) begin
			c = CFGS[r];
			apb(1'b1, spsq_pkg::ADDR_CFG, c);
			if (r == 2) begin
				req(3);
				repeat (3) @(posedge sys_clk);
				chk("gated", {stbyActive, oscEn}, 2'b00);
			end
			req(SRC[r]);
			wait_state(3'd4);
			chk("state", q[2:0], 3'd4);
			repeat (2) @(posedge sys_clk);
			chk("ref", refEn, !c[0]);
			chk("mon", porMonEn, !(c[0] | c[1]));
			chk("osc", oscEn, !(c[0] | c[2] | c[3]));
			chk("pll", pllPwrEn, (c[0] | c[4]) ? 0 : 3);
			chk("diff", diffBufEn, c[0] ? 0 : mBank);
			chk("ibuf", ibufEn, c[5] ? 0 : (mIb[7:0] ^ 8'hFF));
			chk("keep", {ioRelease, lpDetEn, stbyActive, clkNetEn}, {3'b111, mClk[7:0]});
			if (r == 0) begin
				// With the reference off only the fallback detector may judge the supply.
				coreSupplyOk <= 1'b0;
				repeat (3) @(posedge sys_clk);
				chk("fallback", ioRelease, 1'b1);
				coreSupplyOk <= 1'b1;
			end
			if (r == 1) begin
				apb(1'b1, spsq_pkg::ADDR_PLLDIS, 32'h1);
				mPll = 32'h1;
			end
			req(WAKE[r]);
			for (n = 0; n < 400 && stbyActive !== 1'b0; n++) @(posedge sys_clk);
			repeat (4) @(posedge sys_clk);
			chk("wake", {refEn, porMonEn, oscEn, pllPwrEn, stbyActive}, {2'b11, !c[3], ~mPll[1:0], 1'b0});
			apb(1'b1, spsq_pkg::ADDR_PLLDIS, 32'h0);
			mPll = 32'h0;
		end
		// A supply drop with monitoring on forces a reload.
		apb(1'b1, spsq_pkg::ADDR_CFG, 32'h40);
		coreSupplyOk <= 1'b0;
		repeat (4) @(posedge sys_clk);
		apb(1'b0, spsq_pkg::ADDR_STATUS, 32'h0);
		chk("fault", {ioRelease, q[2:0]}, 4'h0);
		coreSupplyOk <= 1'b1;
		wait_state(3'd2);
		chk("reload", q, 32'h32);
		apb(1'b1, spsq_pkg::ADDR_CFG, 32'h0);
		coreSupplyOk <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("nomon", ioRelease, 1'b1);
		coreSupplyOk <= 1'b1;
		tally_and_finish();
	end
endmodule : tb

// >>> common/spsq_ctl_if.sv
// Signals between the sequencer core, its request gate and its PLL controller.
`timescale 1ns/100ps
interface spsq_ctl_if #(parameter int NPLL = 2);
	logic toggleEvt; // Standby pin changed level.
	logic stdbyEvt; // Enter-standby request from a master or core.
	logic wakeEvt; // Wake request from a master or core.
	logic wakeFeatEn; // Wake-up feature option.
	logic [NPLL-1:0] pllStop; // Ask each PLL to power down.
	logic [NPLL-1:0] pllDis; // Static disable of each PLL.
	logic [NPLL-1:0] pllStopped; // PLL is powered down.
	modport ctl(input toggleEvt, stdbyEvt, wakeEvt, pllStopped, output wakeFeatEn, pllStop, pllDis);
	modport gate(output toggleEvt, stdbyEvt, wakeEvt, input wakeFeatEn);
	modport pll(input pllStop, pllDis, output pllStopped);
endinterface : spsq_ctl_if

// >>> common/spsq_pkg.sv
// Shared constants, register map and state type of the standby and power-on sequencer.
package spsq_pkg;
	// Register byte offsets on the APB port.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_PLLDIS = 8'h08;
	localparam logic [7:0] ADDR_BANKEN = 8'h0C;
	localparam logic [7:0] ADDR_CLKEN = 8'h10;
	localparam logic [7:0] ADDR_IBGATE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Control register command bits, write one to act.
	localparam int CTRL_STBY = 0;
	localparam int CTRL_WAKE = 1;
	// Configuration register bit positions.
	localparam int CFG_REF_OFF = 0;
	localparam int CFG_MON_OFF = 1;
	localparam int CFG_OSC_STBY = 2;
	localparam int CFG_OSC_STATIC = 3;
	localparam int CFG_PLL_STBY = 4;
	localparam int CFG_IBUF_STBY = 5;
	localparam int CFG_USER_MON = 6;
	localparam int CFG_WAKE_FEAT = 7;
	localparam int CFG_W = 8;
	// Reset values of the configuration registers.
	localparam logic [7:0] CFG_RST = 8'h40;
	localparam logic PLLDIS_RST = 1'b0;
	localparam logic BANKEN_RST = 1'b1;
	localparam logic CLKEN_RST = 1'b1;
	localparam logic IBGATE_RST = 1'b0;
	// Status register field positions.
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STBY = 3;
	localparam int STAT_IOREL = 4;
	localparam int STAT_REF = 5;
	// Settle times after wake-up, in nanoseconds, and the clock period.
	localparam int CLK_PERIOD_NS = 4;
	localparam int REF_SETTLE_NS = 200;
	localparam int DEP_SETTLE_NS = 400;
	// Least times round up to whole cycles.
	localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEP_SETTLE_CYC = (DEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_POR_WAIT,
		ST_CFG_LOAD,
		ST_USER,
		ST_STBY_PLL,
		ST_STANDBY,
		ST_WAKE_REF,
		ST_WAKE_DEP
	} spsq_state_t;
endpackage : spsq_pkg

// >>> src/spsq_pll_ctl.sv
// Powers each PLL down after its outputs are gated and its clocks are low, or at once when it is statically disabled.
`timescale 1ns/100ps
module spsq_pll_ctl #(
	parameter int NPLL = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	spsq_ctl_if.pll ifc,
	input wire logic [NPLL-1:0] pllClkLow,
	output logic [NPLL-1:0] pllPwrEn,
	output logic [NPLL-1:0] pllOutEn
);
	// All state of the PLL controller.
	typedef struct packed {
		logic [NPLL-1:0] pwrEn;
		logic [NPLL-1:0] outEn;
	} spsq_pll_t;
	spsq_pll_t r;
	spsq_pll_t n;

	// Per PLL: gate outputs first, then drop power once the clocks read low.
	always_comb begin
		n = r;
		for (int i = 0; i < NPLL; i++) begin
			if (ifc.pllDis[i]) begin
				// An unused PLL stays off.
				n.pwrEn[i] = 1'b0; // [RULE7]
				n.outEn[i] = 1'b0;
			end else if (ifc.pllStop[i]) begin
				n.outEn[i] = 1'b0;
				// Power only falls after the clocks are low, so no pulse is cut short.
				if (!r.outEn[i] && pllClkLow[i]) begin
					n.pwrEn[i] = 1'b0; // [RULE8] [RULE7]
				end
			end else begin
				// Outputs return one cycle after power is restored.
				n.pwrEn[i] = 1'b1;
				n.outEn[i] = r.pwrEn[i]; // [RULE17]
			end
		end
	end

	// Registers the state.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign ifc.pllStopped = ~r.pwrEn;
	assign pllPwrEn = r.pwrEn;
	assign pllOutEn = r.outEn;
endmodule : spsq_pll_ctl

// >>> src/spsq_req_gate.sv
// Collects standby and wake requests from the pin, external masters and on-chip cores.
`timescale 1ns/100ps
module spsq_req_gate (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	spsq_ctl_if.gate ifc,
	input wire logic stdbyToggle,
	input wire logic extStdbyCmd,
	input wire logic extWakeCmd,
	input wire logic serStdbyReq,
	input wire logic serWakeReq,
	input wire logic tmrWakeReq
);
	// All state of the gate.
	typedef struct packed {
		logic prev;
		logic primed;
		logic toggleEvt;
		logic stdbyEvt;
		logic wakeEvt;
	} spsq_gate_t;
	spsq_gate_t r;
	spsq_gate_t n;

	// Detects pin toggles and merges the request sources into pulses.
	always_comb begin
		n = r;
		n.prev = stdbyToggle;
		n.primed = 1'b1;
		// The first cycle after reset only loads the pin level, so no false toggle appears.
		n.toggleEvt = r.primed & (stdbyToggle ^ r.prev); // [RULE1]
		// Core requests count only while the wake feature is enabled.
		n.stdbyEvt = extStdbyCmd | (ifc.wakeFeatEn & serStdbyReq); // [RULE1] [RULE16]
		n.wakeEvt = extWakeCmd | (ifc.wakeFeatEn & (serWakeReq | tmrWakeReq)); // [RULE16]
	end

	// Registers the state.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign ifc.toggleEvt = r.toggleEvt;
	assign ifc.stdbyEvt = r.stdbyEvt;
	assign ifc.wakeEvt = r.wakeEvt;
endmodule : spsq_req_gate

// >>> src/spsq_seq.sv
// Standby and power-on sequencer top with its APB register file.
// Functional notes
// RULE1: Standby on pin toggle or master instruction.
// RULE2: Standby keeps configuration, logic and I/O alive.
// RULE3: Per-subsystem option to switch off in standby.
// RULE4: Reference off also drops monitor, PLLs, oscillator, buffers.
// RULE5: Monitor may stop; fallback detector stays on.
// RULE6: Oscillator has static and standby off controls.
// RULE7: Each PLL has static and standby off.
// RULE8: PLL powers down only after outputs low. A statically disabled PLL loses outputs and power in the same cycle.
// RULE9: Per-bank dynamic differential buffer enable.
// RULE10: Each primary clock net has dynamic enable.
// RULE11: Input buffer gating for clock/data, in standby.
// RULE12: Valid supplies trigger configuration load.
// RULE13: I/O tristated until configuration completes.
// RULE14: User-mode supply drop resets to monitoring.
// RULE15: Reference off leaves only fallback detector.
// RULE16: Core requests active only with wake feature.
// RULE17: Wake restores reference first, PLL outputs last.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module spsq_seq #(
	parameter int NPLL = 2,
	parameter int NBANK = 4,
	parameter int NCLK = 8,
	parameter int NIBUF = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stdbyToggle,
	input wire logic extStdbyCmd,
	input wire logic extWakeCmd,
	input wire logic serStdbyReq,
	input wire logic serWakeReq,
	input wire logic tmrWakeReq,
	input wire logic coreSupplyOk,
	input wire logic cfgBankSupplyOk,
	input wire logic lpDetOk,
	input wire logic cfgLoadDone,
	input wire logic [NPLL-1:0] pllClkLow,
	output logic refEn,
	output logic porMonEn,
	output logic lpDetEn,
	output logic oscEn,
	output logic [NPLL-1:0] pllPwrEn,
	output logic [NPLL-1:0] pllOutEn,
	output logic [NBANK-1:0] diffBufEn,
	output logic [NCLK-1:0] clkNetEn,
	output logic [NIBUF-1:0] ibufEn,
	output logic ioRelease,
	output logic cfgLoadStart,
	output logic stbyActive
);
	// Settle counts sized for the down-counter.
	localparam logic [spsq_pkg::CNT_W-1:0] REF_CNT = spsq_pkg::CNT_W'(spsq_pkg::REF_SETTLE_CYC);
	localparam logic [spsq_pkg::CNT_W-1:0] DEP_CNT = spsq_pkg::CNT_W'(spsq_pkg::DEP_SETTLE_CYC);

	// All state of the sequencer and its registers.
	typedef struct packed {
		spsq_pkg::spsq_state_t state;
		logic [spsq_pkg::CNT_W-1:0] cnt;
		logic [spsq_pkg::CFG_W-1:0] cfg;
		logic [NPLL-1:0] pllDis;
		logic [NBANK-1:0] bankEn;
		logic [NCLK-1:0] clkEn;
		logic [NIBUF-1:0] ibGate;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic refEn;
		logic porMonEn;
		logic lpDetEn;
		logic oscEn;
		logic [NBANK-1:0] diffEn;
		logic [NCLK-1:0] clkNetEn;
		logic [NIBUF-1:0] ibufEn;
		logic ioRelease;
		logic cfgLoad;
		logic stbyActive;
		logic [NPLL-1:0] pllStop;
	} spsq_seq_t;
	spsq_seq_t r;
	spsq_seq_t n;

	spsq_ctl_if #(.NPLL(NPLL)) ctl ();

	// Request gate for pin, master and core requests.
	spsq_req_gate u_gate (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.ifc(ctl.gate),
		.stdbyToggle(stdbyToggle),
		.extStdbyCmd(extStdbyCmd),
		.extWakeCmd(extWakeCmd),
		.serStdbyReq(serStdbyReq),
		.serWakeReq(serWakeReq),
		.tmrWakeReq(tmrWakeReq)
	);

	// PLL power and output controller.
	spsq_pll_ctl #(.NPLL(NPLL)) u_pll (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.ifc(ctl.pll),
		.pllClkLow(pllClkLow),
		.pllPwrEn(pllPwrEn),
		.pllOutEn(pllOutEn)
	);

	// Combinational helpers.
	logic apbSetup; // Setup cycle of an APB transfer.
	logic apbWrite; // Write completing at this edge.
	logic swStby; // Software standby command.
	logic swWake; // Software wake command.
	logic goStby; // Any request to enter standby.
	logic goWake; // Any request to leave standby.
	logic supplyOk; // Supply verdict of the active detector.
	logic stbyPll; // PLLs must stop for this standby.
	logic stbyPhase; // Device is held in standby.

	// Decodes APB, evaluates requests and runs the power sequence.
	always_comb begin
		n = r;
		n.cfgLoad = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		apbSetup = psel & ~penable;
		apbWrite = psel & penable & r.pready & pwrite & ~r.pslverr;
		swStby = 1'b0;
		swWake = 1'b0;
		// Read data and error are prepared in the setup cycle, ready follows one cycle later.
		if (apbSetup) begin
			n.pready = 1'b1;
			n.prdata = '0;
			case (paddr)
				spsq_pkg::ADDR_CTRL: begin
					n.prdata = '0;
				end
				spsq_pkg::ADDR_CFG: begin
					n.prdata[spsq_pkg::CFG_W-1:0] = r.cfg;
				end
				spsq_pkg::ADDR_PLLDIS: begin
					n.prdata[NPLL-1:0] = r.pllDis;
				end
				spsq_pkg::ADDR_BANKEN: begin
					n.prdata[NBANK-1:0] = r.bankEn;
				end
				spsq_pkg::ADDR_CLKEN: begin
					n.prdata[NCLK-1:0] = r.clkEn;
				end
				spsq_pkg::ADDR_IBGATE: begin
					n.prdata[NIBUF-1:0] = r.ibGate;
				end
				spsq_pkg::ADDR_STATUS: begin
					n.prdata[spsq_pkg::STAT_STATE_LSB+:3] = r.state;
					n.prdata[spsq_pkg::STAT_STBY] = r.stbyActive;
					n.prdata[spsq_pkg::STAT_IOREL] = r.ioRelease;
					n.prdata[spsq_pkg::STAT_REF] = r.refEn;
				end
				default: begin
					// Unmapped addresses answer with an error.
					n.pslverr = 1'b1;
				end
			endcase
		end
		// Writes take effect in the access cycle.
		if (apbWrite) begin
			case (paddr)
				spsq_pkg::ADDR_CTRL: begin
					swStby = pwdata[spsq_pkg::CTRL_STBY];
					swWake = pwdata[spsq_pkg::CTRL_WAKE];
				end
				spsq_pkg::ADDR_CFG: begin
					n.cfg = pwdata[spsq_pkg::CFG_W-1:0]; // [RULE3]
				end
				spsq_pkg::ADDR_PLLDIS: begin
					n.pllDis = pwdata[NPLL-1:0]; // [RULE7]
				end
				spsq_pkg::ADDR_BANKEN: begin
					n.bankEn = pwdata[NBANK-1:0]; // [RULE9]
				end
				spsq_pkg::ADDR_CLKEN: begin
					n.clkEn = pwdata[NCLK-1:0]; // [RULE10]
				end
				spsq_pkg::ADDR_IBGATE: begin
					n.ibGate = pwdata[NIBUF-1:0]; // [RULE11]
				end
				default: begin
					n.cfg = r.cfg;
				end
			endcase
		end
		// A pin toggle enters standby from user mode and wakes from standby.
		goStby = ctl.stdbyEvt | swStby | (ctl.toggleEvt & (r.state == spsq_pkg::ST_USER)); // [RULE1]
		goWake = ctl.wakeEvt | swWake | (ctl.toggleEvt & (r.state == spsq_pkg::ST_STANDBY));
		// With the reference or main monitor off only the fallback detector decides.
		supplyOk = (r.refEn & r.porMonEn) ? coreSupplyOk : lpDetOk; // [RULE15] [RULE5]
		stbyPll = r.cfg[spsq_pkg::CFG_PLL_STBY] | r.cfg[spsq_pkg::CFG_REF_OFF]; // [RULE4]
		case (r.state)
			spsq_pkg::ST_POR_WAIT: begin
				// Reference, monitor and oscillator on, PLLs held off, I/O held in high impedance.
				n.refEn = 1'b1;
				n.porMonEn = 1'b1;
				n.oscEn = 1'b1;
				n.ioRelease = 1'b0; // [RULE13]
				n.stbyActive = 1'b0;
				if (coreSupplyOk && cfgBankSupplyOk) begin
					n.cfgLoad = 1'b1; // [RULE12]
					n.state = spsq_pkg::ST_CFG_LOAD;
				end
			end
			spsq_pkg::ST_CFG_LOAD: begin
				// I/O are released only when the image has loaded.
				if (cfgLoadDone) begin
					n.ioRelease = 1'b1; // [RULE13]
					n.state = spsq_pkg::ST_USER;
				end
			end
			spsq_pkg::ST_USER: begin
				n.oscEn = ~r.cfg[spsq_pkg::CFG_OSC_STATIC]; // [RULE6]
				if (goStby) begin
					n.stbyActive = 1'b1;
					n.state = spsq_pkg::ST_STBY_PLL;
				end
			end
			spsq_pkg::ST_STBY_PLL: begin
				// PLLs stop first; the other subsystems wait until they are down.
				if (!stbyPll || (&(ctl.pllStopped | r.pllDis))) begin // [RULE8]
					n.state = spsq_pkg::ST_STANDBY;
					if (r.cfg[spsq_pkg::CFG_REF_OFF]) begin
						// Everything biased from the reference goes off with it.
						n.refEn = 1'b0; // [RULE4] [RULE3]
						n.porMonEn = 1'b0; // [RULE15]
						n.oscEn = 1'b0;
					end
					if (r.cfg[spsq_pkg::CFG_MON_OFF]) begin
						n.porMonEn = 1'b0; // [RULE5]
					end
					if (r.cfg[spsq_pkg::CFG_OSC_STBY]) begin
						n.oscEn = 1'b0; // [RULE6]
					end
				end
			end
			spsq_pkg::ST_STANDBY: begin
				// Configuration and I/O stay as they are while waiting.
				if (goWake) begin
					n.refEn = 1'b1; // [RULE17]
					n.cnt = REF_CNT;
					n.state = spsq_pkg::ST_WAKE_REF;
				end
			end
			spsq_pkg::ST_WAKE_REF: begin
				// Dependent circuits return only after the reference has settled.
				if (r.cnt <= 1) begin
					n.porMonEn = 1'b1; // [RULE17]
					n.oscEn = ~r.cfg[spsq_pkg::CFG_OSC_STATIC];
					n.cnt = DEP_CNT;
					n.state = spsq_pkg::ST_WAKE_DEP;
				end else begin
					n.cnt = r.cnt - 1'b1;
				end
			end
			spsq_pkg::ST_WAKE_DEP: begin
				// PLLs restart after the dependent circuits have settled.
				if (r.cnt <= 1) begin
					n.stbyActive = 1'b0; // [RULE17]
					n.state = spsq_pkg::ST_USER;
				end else begin
					n.cnt = r.cnt - 1'b1;
				end
			end
			default: begin
				n.state = spsq_pkg::ST_POR_WAIT;
			end
		endcase
		// A supply drop after configuration returns to supply monitoring.
		if (r.ioRelease && r.cfg[spsq_pkg::CFG_USER_MON] && !supplyOk) begin
			n.state = spsq_pkg::ST_POR_WAIT; // [RULE14]
			n.ioRelease = 1'b0;
			n.stbyActive = 1'b0;
		end
		stbyPhase = (n.state == spsq_pkg::ST_STANDBY) || (n.state == spsq_pkg::ST_WAKE_REF);
		// The fallback detector never stops.
		n.lpDetEn = 1'b1; // [RULE5]
		// Differential buffers follow the bank enables and are dropped with the reference.
		n.diffEn = r.bankEn & {NBANK{n.ioRelease & ~(stbyPhase & r.cfg[spsq_pkg::CFG_REF_OFF])}}; // [RULE9] [RULE4]
		// Clock nets keep running in standby so the logic stays functional.
		n.clkNetEn = r.clkEn & {NCLK{n.ioRelease}}; // [RULE10] [RULE2]
		n.ibufEn = ~(r.ibGate | {NIBUF{stbyPhase & r.cfg[spsq_pkg::CFG_IBUF_STBY]}}); // [RULE11]
		// PLLs are held off before configuration and during standby when selected.
		if (!n.ioRelease) begin
			n.pllStop = '1;
		end else if (n.state == spsq_pkg::ST_USER) begin
			n.pllStop = '0; // [RULE17]
		end else begin
			n.pllStop = {NPLL{stbyPll}}; // [RULE7] [RULE4]
		end
	end

	// Registers the state; a low clock enable freezes everything.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= spsq_pkg::ST_POR_WAIT;
			r.cfg <= spsq_pkg::CFG_RST;
			r.pllDis <= {NPLL{spsq_pkg::PLLDIS_RST}};
			r.bankEn <= {NBANK{spsq_pkg::BANKEN_RST}};
			r.clkEn <= {NCLK{spsq_pkg::CLKEN_RST}};
			r.ibGate <= {NIBUF{spsq_pkg::IBGATE_RST}};
			r.refEn <= 1'b1;
			r.porMonEn <= 1'b1;
			r.lpDetEn <= 1'b1;
			r.oscEn <= 1'b1;
			r.pllStop <= '1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign ctl.wakeFeatEn = r.cfg[spsq_pkg::CFG_WAKE_FEAT]; // [RULE16]
	assign ctl.pllStop = r.pllStop;
	assign ctl.pllDis = r.pllDis;
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign refEn = r.refEn;
	assign porMonEn = r.porMonEn;
	assign lpDetEn = r.lpDetEn;
	assign oscEn = r.oscEn;
	assign diffBufEn = r.diffEn;
	assign clkNetEn = r.clkNetEn;
	assign ibufEn = r.ibufEn;
	assign ioRelease = r.ioRelease;
	assign cfgLoadStart = r.cfgLoad;
	assign stbyActive = r.stbyActive;
endmodule : spsq_seq
